/* File: hw/dscp_serial_power.sv */
// serial frame port, reset handling and power state of a single-channel converter
// Operation
// - reset restores defaults; host waits delay
// - software reset acts as power-on reset
// - after reset converter and reference powered down
// - over-temperature sets alarm, powers converter down
// - fault pin reports alarm only when enabled
// - alarm latched after temperature falls back
// - alarm clear needs trigger, cool, converter down
// - converter down disables amplifier, clamps output
// - data register kept through power-down
// - data writes accepted while powered down
// - chip power-down bit overrides converter and reference bits
// - frame opens low select, sample falling
// - select high ends frame; short discarded
// - extra bits beyond frame length ignored
// - select high blocks inputs, output floats
// - frame msb first: flag, x, address, payload
// - write stores payload; read ignores payload
// - second frame returns echo and data
// - output launch edge chosen by config
// - select rising edge ends access cycle
// - pattern 1010 in trigger resets at end
// - check enable lengthens frame to 32
`timescale 1ns/1ps
`default_nettype none
module dscp_serial_power
  import dscp_pkg::*;
#(
  parameter int PorCycles = POR_CYCLES
) (
  // system
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // serial link
  input wire logic sclk,
  input wire logic selectN,
  input wire logic serial_in,
  output logic serial_out,
  output logic serialOutEn,
  // analog status and controls
  input wire logic overTemp,
  output logic faultN,
  output logic ampEnable,
  output logic outClamp,
  output logic refPowerdown,
  output logic chipActive,
  output logic [15:0] convCode,
  output logic linkReady
);

  // wide enough to hold the whole start-up count
  localparam int PorW = $clog2(PorCycles + 1);

  // link domain: shift-in and shift-out on sclk
  logic fresh;
  logic [5:0] edgeCount;
  logic [BUF_LEN-1:0] frameBuf;
  logic outFall;
  logic outRise;
  logic [23:0] readWord;
  logic outEdgeSel;
  logic outDriverEn;

  // fresh marks a frame not yet clocked; set only while select is high
  always_ff @(negedge sclk or posedge selectN) begin
    if (selectN) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // no reset here: sclk may stand still while rst_b is low
  // counter and buffer move only while select is low
  always_ff @(negedge sclk) begin
    if (!selectN) begin
      if (fresh) begin
        edgeCount <= 6'h01;
      end else if (edgeCount <= 6'(BUF_LEN)) begin
        edgeCount <= edgeCount + 6'h01;
      end
    end
  end

  // bits land by position, so the first 24 or 32 stay put however long the frame
  always_ff @(negedge sclk) begin
    if (!selectN) begin
      if (fresh) begin
        frameBuf[BUF_LEN-1] <= serial_in;
      end else if (edgeCount < 6'(BUF_LEN)) begin
        frameBuf[5'(BUF_LEN - 1 - int'(edgeCount))] <= serial_in;
      end
    end
  end

  // launch on falling edge: next bit after edge n is word[22-(n-1)]
  always_ff @(negedge sclk) begin
    if (!selectN) begin
      if (edgeCount >= 6'd24 && !fresh) begin
        outFall <= 1'b0;
      end else if (fresh) begin
        outFall <= readWord[FRAME_X_BIT];
      end else begin
        outFall <= (edgeCount < 6'd23) ? readWord[5'(22 - int'(edgeCount))] : 1'b0;
      end
    end
  end

  // launch on rising edge: bit for the coming falling edge
  always_ff @(posedge sclk) begin
    if (!selectN) begin
      if (fresh) begin
        outRise <= readWord[FRAME_RW_BIT];
      end else begin
        outRise <= (edgeCount < 6'd24) ? readWord[5'(23 - int'(edgeCount))] : 1'b0;
      end
    end
  end

  // pin level; before the first edge the falling mode shows the top bit
  // a mux, not a flop: the pin must follow whichever sclk edge launches
  assign serial_out = outEdgeSel ? outRise : (fresh ? readWord[FRAME_RW_BIT] : outFall);
  // enable follows select at once, there is no sclk edge to wait for
  assign serialOutEn = !selectN && outDriverEn;

  // system domain: select synchroniser
  logic selS1;
  logic selS2;
  logic selS3;
  logic selStable;
  logic frameEnd;

  // ce freezes the synchronisers along with all other clk-domain state; the sclk-side flops ignore it
  always_ff @(posedge clk) begin
    if (ce) begin
      selS1 <= selectN;
      selS2 <= selS1;
      selS3 <= selS2;
    end
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      selStable <= 1'b1;
    end else if (ce && selS2 == selS3) begin
      selStable <= selS3;
    end
  end

  assign frameEnd = ce && !selStable && selS2 && selS3;

  // over-temperature synchroniser
  logic hotS1;
  logic hotS2;
  logic hotS3;
  logic hot;

  always_ff @(posedge clk) begin
    if (ce) begin
      hotS1 <= overTemp;
      hotS2 <= hotS1;
      hotS3 <= hotS2;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hot <= 1'b0;
    end else if (ce && hotS2 == hotS3) begin
      hot <= hotS3;
    end
  end

  // frame decode; buffer is quiet while select is high, so it is read as a static word
  logic [5:0] lenNeed;
  logic frameFull;
  logic porDone;
  logic frameOk;
  logic frameRead;
  logic [5:0] frameAddr;
  logic [15:0] framePayload;
  logic softReset;
  logic resetNow;
  logic softPending;
  logic [15:0] serialConfig;

  // check enable only lengthens the frame; the check byte itself is not verified
  assign lenNeed = serialConfig[CFG_CHECK_ENABLE] ? 6'(FRAME_LEN_CHECKED)
                                                  : 6'(FRAME_LEN_PLAIN);
  assign frameFull = edgeCount >= lenNeed;
  assign frameOk = frameEnd && frameFull && porDone;
  assign frameRead = frameBuf[BUF_LEN-1];
  assign frameAddr = frameBuf[BUF_LEN-3 -: 6];
  assign framePayload = frameBuf[BUF_LEN-9 -: 16];
  assign softReset = frameOk && !frameRead && frameAddr == ADDR_TRIGGER
    && framePayload[TRG_RESET_HI:TRG_RESET_LO] == TRG_RESET_CODE;
  assign resetNow = !rst_b || (ce && softPending);

  // software reset is held one cycle, then handled like the reset pin, except that selStable and hot keep their values
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      softPending <= 1'b0;
    end else if (ce) begin
      softPending <= softReset;
    end
  end

  // start-up delay counter
  logic [PorW-1:0] porCount;
  always_ff @(posedge clk) begin
    if (resetNow) begin
      porCount <= '0;
    end else if (ce && !porDone) begin
      porCount <= porCount + PorW'(1);
    end
  end
  assign porDone = porCount >= PorW'(PorCycles);

  // write strobes
  logic writeOk;
  assign writeOk = frameOk && !frameRead;

  // serial configuration register
  always_ff @(posedge clk) begin
    if (resetNow) begin
      serialConfig <= CFG_RESET;
    end else if (writeOk && frameAddr == ADDR_SERIAL_CONFIG) begin
      serialConfig <= framePayload & CFG_MASK;
    end
  end

  // power configuration register
  logic [15:0] powerConfig;
  always_ff @(posedge clk) begin
    if (resetNow) begin
      powerConfig <= PWR_RESET;
    end else if (writeOk && frameAddr == ADDR_POWER_CONFIG) begin
      powerConfig <= framePayload & PWR_MASK;
    end
  end

  // converter data survives power-down and takes writes during it
  logic [15:0] convData;
  always_ff @(posedge clk) begin
    if (resetNow) begin
      convData <= DATA_RESET;
    end else if (writeOk && frameAddr == ADDR_CONV_DATA) begin
      convData <= framePayload;
    end
  end

  // thermal alarm: set wins over a clear in the same cycle
  // a clear written while still hot is lost; the host must send it again
  logic thermalAlarm;
  logic alarmClear;
  assign alarmClear = writeOk && frameAddr == ADDR_TRIGGER
    && framePayload[TRG_ALARM_CLEAR] && !hot
    && powerConfig[PWR_CONV_POWERDOWN];
  always_ff @(posedge clk) begin
    if (resetNow) begin
      thermalAlarm <= 1'b0;
    end else if (ce && hot) begin
      thermalAlarm <= 1'b1;
    end else if (alarmClear) begin
      thermalAlarm <= 1'b0;
    end
  end

  // readback word, captured at the end of a read frame for the next one
  logic [15:0] readData;
  always_comb begin
    readData = 16'h0000;
    case (frameAddr)
      ADDR_STATUS: begin
        readData[STS_THERMAL_ALARM] = thermalAlarm;
      end
      ADDR_SERIAL_CONFIG: begin
        readData = serialConfig;
      end
      ADDR_POWER_CONFIG: begin
        readData = powerConfig;
      end
      ADDR_CONV_DATA: begin
        readData = convData;
      end
      default: begin
        readData = 16'h0000;
      end
    endcase
  end

  // stable through the following frame, since it only changes while select is high
  always_ff @(posedge clk) begin
    if (resetNow) begin
      readWord <= 24'h000000;
    end else if (frameOk && frameRead) begin
      readWord <= {frameBuf[BUF_LEN-1 -: 8], readData};
    end
  end

  // config bits used by the link side are quasi-static between frames
  always_ff @(posedge clk) begin
    if (resetNow) begin
      outEdgeSel <= 1'b0;
      outDriverEn <= 1'b0;
    end else if (ce) begin
      outEdgeSel <= serialConfig[CFG_OUT_EDGE_SELECT];
      outDriverEn <= serialConfig[CFG_OUT_DRIVER_ENABLE];
    end
  end

  // analog controls, all registered
  // the alarm takes the converter down but leaves the reference on
  logic convDown;
  assign convDown = powerConfig[PWR_CONV_POWERDOWN] || powerConfig[PWR_CHIP_POWERDOWN]
    || thermalAlarm;
  always_ff @(posedge clk) begin
    if (resetNow) begin
      ampEnable <= 1'b0;
      outClamp <= 1'b1;
      refPowerdown <= 1'b1;
      chipActive <= 1'b1;
      faultN <= 1'b1;
      convCode <= DATA_RESET;
      linkReady <= 1'b0;
    end else if (ce) begin
      ampEnable <= !convDown;
      outClamp <= convDown;
      refPowerdown <= powerConfig[PWR_REF_POWERDOWN] || powerConfig[PWR_CHIP_POWERDOWN];
      chipActive <= !powerConfig[PWR_CHIP_POWERDOWN];
      faultN <= !(thermalAlarm && serialConfig[CFG_THERMAL_FAULT_ENABLE]);
      convCode <= convData;
      linkReady <= porDone;
    end
  end

endmodule
`default_nettype wire

/* File: hw/dscp_pkg.sv */
// constants shared by the serial control and power state block
package dscp_pkg;
  // clock and start-up timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam longint POR_DELAY_PS = 64'd1000000000;
  localparam int POR_CYCLES = int'((POR_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // frame layout
  localparam int FRAME_LEN_PLAIN = 24;
  localparam int FRAME_LEN_CHECKED = 32;
  localparam int BUF_LEN = 32;
  localparam int FRAME_RW_BIT = 23;
  localparam int FRAME_X_BIT = 22;
  localparam int FRAME_ADDR_HI = 21;
  localparam int FRAME_ADDR_LO = 16;
  localparam int FRAME_DATA_HI = 15;

  // register addresses
  localparam logic [5:0] ADDR_NOP = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h02;
  localparam logic [5:0] ADDR_SERIAL_CONFIG = 6'h03;
  localparam logic [5:0] ADDR_POWER_CONFIG = 6'h04;
  localparam logic [5:0] ADDR_TRIGGER = 6'h0e;
  localparam logic [5:0] ADDR_CONV_DATA = 6'h10;

  // serial_config_reg fields
  localparam int CFG_THERMAL_FAULT_ENABLE = 0;
  localparam int CFG_OUT_EDGE_SELECT = 1;
  localparam int CFG_OUT_DRIVER_ENABLE = 2;
  localparam int CFG_CHECK_ENABLE = 3;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_MASK = 16'h000f;

  // power config fields
  localparam int PWR_CONV_POWERDOWN = 0;
  localparam int PWR_REF_POWERDOWN = 1;
  localparam int PWR_CHIP_POWERDOWN = 2;
  localparam logic [15:0] PWR_RESET = 16'h0003;
  localparam logic [15:0] PWR_MASK = 16'h0007;

  // trigger fields
  localparam int TRG_RESET_LO = 0;
  localparam int TRG_RESET_HI = 3;
  localparam logic [3:0] TRG_RESET_CODE = 4'ha;
  localparam int TRG_ALARM_CLEAR = 4;

  // status fields
  localparam int STS_THERMAL_ALARM = 0;

  localparam logic [15:0] DATA_RESET = 16'h0000;
endpackage

/* File: verif/dscp_props.sv */
// assertion checker for the serial power block
`timescale 1ns/1ps
`default_nettype none
module dscp_props
  import dscp_pkg::*;
#(
  parameter int PorCycles = POR_CYCLES
) (
  // system
  input wire logic clk,
  input wire logic rst_b,
  // watched pins
  input wire logic selectN,
  input wire logic overTemp,
  input wire logic serialOutEn,
  input wire logic faultN,
  input wire logic ampEnable,
  input wire logic outClamp,
  input wire logic refPowerdown,
  input wire logic chipActive,
  input wire logic [15:0] convCode,
  input wire logic linkReady
);
  // cycles spent waiting for the start-up delay
  int lowCnt;
  always_ff @(posedge clk) begin
    lowCnt <= (!rst_b || linkReady) ? 0 : lowCnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_float_idle: assert property (selectN |-> !serialOutEn)
    else $error("output driven while idle");
  a_reset_state: assert property ($rose(rst_b) |-> outClamp && refPowerdown && !ampEnable
    && chipActive && faultN && !linkReady && convCode == 16'h0000) else $error("reset state");
  a_ready_wait: assert property ($rose(linkReady) |-> lowCnt >= PorCycles - 1)
    else $error("ready too early");
  a_ready_bound: assert property (!linkReady |-> lowCnt <= PorCycles + 4)
    else $error("ready too late");
  a_code_idle: assert property ($changed(convCode) |-> selectN && $past(selectN)
    && $past(selectN, 2)) else $error("code changed inside frame");
  a_fault_hold: assert property ($rose(faultN) |-> selectN && $past(selectN))
    else $error("fault released without frame");
  a_hot_down: assert property (overTemp [*4] |-> ##[0:6] !ampEnable)
    else $error("amplifier on while hot");
  a_alarm_down: assert property (!faultN && !$past(faultN) |-> !ampEnable)
    else $error("amplifier on with alarm");
  a_clamp_amp: assert property (ampEnable |-> !outClamp)
    else $error("clamp with amplifier on");
  a_chip_down: assert property (!chipActive && !$past(chipActive) |-> !ampEnable
    && refPowerdown) else $error("chip down not honoured");
endmodule
`default_nettype wire

/* File: verif/dscp_host.sv */
// host model driving frames on the link
`timescale 1ns/1ps
`default_nettype none
module dscp_host (
  // link
  output logic sclk,
  output logic selectN,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    sclk = 1'b0;
    selectN = 1'b1;
    serial_in = 1'b0;
  end
  // n bits sent from the top of w; the answer lands in rx the same way
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rx);
    rx = 32'h0;
    #7 selectN = 1'b0;
    for (int i = 0; i < n; i++) begin
      #1 serial_in = w[31-i];
      #14 sclk = 1'b1;
      #8 rx[31-i] = serial_out;
      #7 sclk = 1'b0;
    end
    #15 selectN = 1'b1;
    // released line must not look like held data
    serial_in = ~serial_in;
    #90;
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the serial power block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dscp_pkg::*;
;
  localparam int Por = 100;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic overTemp = 1'b0;
  logic sclk, selectN, serial_in, serial_out, serialOutEn;
  logic faultN, ampEnable, outClamp, refPowerdown, chipActive, linkReady;
  logic [15:0] convCode;
  logic [31:0] rx;
  int len = 24;
  int bad_count = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  dscp_serial_power #(.PorCycles(Por)) dscp_serial_power_i (.clk, .rst_b, .ce(1'b1), .sclk,
    .selectN, .serial_in, .serial_out, .serialOutEn, .overTemp, .faultN, .ampEnable, .outClamp,
    .refPowerdown, .chipActive, .convCode, .linkReady);
  dscp_host dscp_host_i (.sclk, .selectN, .serial_in, .serial_out);
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic frame(input logic [23:0] w, input int n);
    @(negedge clk);
    dscp_host_i.xfer({w, 8'hff}, n, rx);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    frame({2'b00, a, d}, len);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] d);
    frame({2'b10, a, 16'h0000}, len);
    frame({2'b00, ADDR_NOP, 16'h0000}, len);
    chk("readback", {2'b10, a, d}, rx[31:8]);
  endtask
  // amp, clamp, ref down, chip active, fault
  task automatic st(input logic [4:0] e);
    chk("pins", {19'h0, e}, {19'h0, ampEnable, outClamp, refPowerdown, chipActive, faultN});
  endtask
  task automatic code(input logic [15:0] e);
    chk("code", {8'h00, e}, {8'h00, convCode});
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 3 * Por && linkReady !== 1'b1; i++) @(negedge clk);
    chk("ready", 24'h1, {23'h0, linkReady});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    st(5'b01111);
    wr(ADDR_CONV_DATA, 16'h1111);
    code(16'h0000);
    wait_ready();
    $display("test reset done");
    wr(ADDR_SERIAL_CONFIG, 16'h0005);
    rd(ADDR_SERIAL_CONFIG, 16'h0005);
    rd(ADDR_POWER_CONFIG, PWR_RESET);
    wr(ADDR_CONV_DATA, 16'hbeef);
    code(16'hbeef);
    st(5'b01111);
    wr(ADDR_POWER_CONFIG, 16'h0000);
    st(5'b10011);
    wr(ADDR_POWER_CONFIG, 16'h0004);
    st(5'b01101);
    wr(ADDR_POWER_CONFIG, 16'h0001);
    st(5'b01011);
    code(16'hbeef);
    $display("test power done");
    frame({2'b00, ADDR_CONV_DATA, 16'h1234}, 20);
    code(16'hbeef);
    frame({2'b00, ADDR_CONV_DATA, 16'h1234}, 28);
    code(16'h1234);
    wr(ADDR_SERIAL_CONFIG, 16'h0007);
    rd(ADDR_CONV_DATA, 16'h1234);
    wr(ADDR_SERIAL_CONFIG, 16'h000f);
    wr(ADDR_CONV_DATA, 16'h5555);
    code(16'h1234);
    len = 32;
    wr(ADDR_CONV_DATA, 16'h5555);
    rd(ADDR_CONV_DATA, 16'h5555);
    wr(ADDR_SERIAL_CONFIG, 16'h0005);
    len = 24;
    $display("test frames done");
    wr(ADDR_POWER_CONFIG, 16'h0000);
    overTemp = 1'b1;
    repeat (12) @(negedge clk);
    chk("hot", 24'h0, {21'h0, ampEnable, refPowerdown, faultN});
    rd(ADDR_STATUS, 16'h0001);
    overTemp = 1'b0;
    repeat (12) @(negedge clk);
    wr(ADDR_TRIGGER, 16'h0010);
    chk("latched", 24'h0, {23'h0, faultN});
    wr(ADDR_SERIAL_CONFIG, 16'h0004);
    chk("unreported", 24'h1, {23'h0, faultN});
    wr(ADDR_SERIAL_CONFIG, 16'h0005);
    wr(ADDR_POWER_CONFIG, 16'h0001);
    wr(ADDR_TRIGGER, 16'h0010);
    rd(ADDR_STATUS, 16'h0000);
    chk("cleared", 24'h1, {23'h0, faultN});
    $display("test thermal done");
    wr(ADDR_TRIGGER, {12'h000, TRG_RESET_CODE});
    code(16'h0000);
    st(5'b01111);
    chk("restart", 24'h0, {23'h0, linkReady});
    wait_ready();
    $display("test soft reset done");
    end_of_test();
  end
endmodule
bind dscp_serial_power dscp_props #(.PorCycles(PorCycles)) dscp_props_i (.clk, .rst_b, .selectN,
  .overTemp, .serialOutEn, .faultN, .ampEnable, .outClamp, .refPowerdown, .chipActive, .convCode,
  .linkReady);
`default_nettype wire
